// File: design/cie_exec.sv
// Purpose : Execution timing and results for an instruction subset
// Assumes : Decoded op arrives with operands, taken when o_ready high
// Notes   : Extra cycles are idle fill; unlisted flags hold
// Notes on behaviour
// - Second word top eight bits zero, alone is nop
// - Two-word instructions take two cycles, except the two-word jump at four
// - Branches, true tests, table reads add cycles
// - Taken skip: two or three cycles
// - Double-word moves take two cycles
// - Peripheral register reads add one cycle on logic ops only
// - Decimal adjust in place, carry only
// - Interrupt hold for literal cycles, no flags
// - Divides take eighteen cycles, update N Z C OV
// - Hardware loop count plus one, two cycles
// - Distance square, one cycle, accumulator flags
// - Bit scans write position, carry only
// - Jump takes four cycles, no flags
// - Shift by one sets C N OV Z; multi N Z
// - Multiply accumulate one cycle, accumulator flags
// - Write-back only to W13 or [W13]+=2
// - Literal limited 255 byte, 1023 word
`default_nettype none
module cie_exec
  import cie_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic                 i_mclk,       // Instruction clock
  input  wire logic                 i_rst,        // Sync reset, high
  input  wire logic                 i_ce,         // Clock enable
  input  wire logic                 i_valid,      // Op presented
  input  wire cie_pkg::cie_op_t     i_op,         // Decoded op
  input  wire logic                 i_word2_alone,// Second word fetched as op
  input  wire logic [23:0]          i_word2,      // Second instruction word
  input  wire logic                 i_cond_true,  // Conditional test true
  input  wire logic                 i_skip_two,   // Skipped op is two words
  input  wire logic                 i_sfr_access, // Targets peripheral register
  input  wire logic                 i_table_read, // Table/program view read
  input  wire logic                 i_jump_long,  // Two-word jump form
  input  wire logic                 i_byte_mode,  // Byte operand size
  input  wire logic                 i_acc_sel,    // 0 acc A, 1 acc B
  input  wire logic                 i_awb_en,     // Accumulator write-back
  input  wire logic                 i_awb_ind,    // Write-back via [W13]+=2
  input  wire logic [DW-1:0]        i_opa,        // Operand A / dividend low
  input  wire logic [DW-1:0]        i_opb,        // Operand B / divisor
  input  wire logic [DW-1:0]        i_opc,        // Dividend high word
  input  wire logic [9:0]           i_lit,        // Literal field
  input  wire logic [DW-1:0]        i_w13,        // Current W13
  output logic                      o_ready,      // Accepting a new op
  output logic                      o_done,       // Op completes this cycle
  output logic                      o_wr_en,      // Result write
  output logic [DW-1:0]             o_result,     // Result value
  output logic [DW-1:0]             o_remainder,  // Divide remainder
  output logic                      o_awb_wr,     // Write-back strobe
  output logic [3:0]                o_awb_reg,    // Write-back register
  output logic [DW-1:0]             o_awb_data,   // Write-back data
  output logic [DW-1:0]             o_w13_next,   // W13 after post increment
  output logic [CIE_NF-1:0]         o_flags,      // Status flags
  output logic                      o_irq_block,  // Interrupts held off
  output logic                      o_loop_act,   // Hardware loop active
  output logic [14:0]               o_loop_count, // Loop passes remaining
  output logic                      o_lit_err     // Literal out of range
);
  import cie_pkg::*;
  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {CIE_IDLE = 2'b00, CIE_BUSY = 2'b01} cie_st_t;
  cie_st_t     st_reg;
  logic [4:0]  cnt_reg;
  logic [4:0]  cyc_need;
  logic        take;
  logic [CIE_NF-1:0] flags_reg;
  logic [CIE_AW-1:0] acca_reg, accb_reg;

  assign o_ready = (st_reg == CIE_IDLE);
  assign take    = i_ce & i_valid & o_ready;

  always_comb begin
    unique case (i_op)
      CIE_OP_DIV_S, CIE_OP_DIV_SD, CIE_OP_DIV_U, CIE_OP_DIV_UD,
      CIE_OP_FRACTIONAL_DIVIDE_OP: cyc_need = CIE_DIV_CYC;
      CIE_OP_JUMP: cyc_need = CIE_JUMP_CYC;
      CIE_OP_LOOP: cyc_need = CIE_TWO_CYC;
      CIE_OP_MOVD: cyc_need = CIE_TWO_CYC;
      CIE_OP_SKIP: cyc_need = !i_cond_true ? CIE_ONE_CYC :
                              (i_skip_two ? CIE_SKIP2_CYC : CIE_TWO_CYC);
      CIE_OP_LOGIC: cyc_need = CIE_ONE_CYC + 5'(i_sfr_access)
                               + 5'(i_table_read);
      default:     cyc_need = CIE_ONE_CYC + 5'(i_table_read);
    endcase
    if (i_word2_alone) cyc_need = CIE_ONE_CYC;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg  <= CIE_IDLE;
      cnt_reg <= 5'h00;
    end else if (i_ce) begin
      if (take && cyc_need > CIE_ONE_CYC) begin
        st_reg  <= CIE_BUSY;
        cnt_reg <= cyc_need - CIE_ONE_CYC;
      end else if (st_reg == CIE_BUSY) begin
        cnt_reg <= cnt_reg - 5'h01;
        if (cnt_reg == 5'h01) st_reg <= CIE_IDLE;
      end
    end
  end

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  logic [DW-1:0] daw_v;
  logic          daw_c;
  logic [4:0]    scan_pos;
  logic          scan_none;
  logic [1:0]    scan_mode;
  logic [CIE_AW-1:0] mac_out;
  logic          mac_ovf, mac_sat;
  logic signed [DW-1:0] dist_d;

  always_comb begin
    daw_v = i_opa;
    daw_c = flags_reg[CIE_F_C];
    if (daw_v[3:0] > 4'h9) daw_v[7:0] = daw_v[7:0] + 8'h06;
    if (daw_v[7:4] > 4'h9 || flags_reg[CIE_F_C]) begin
      {daw_c, daw_v[7:4]} = {1'b0, daw_v[7:4]} + 5'h06;
      daw_c = daw_c | flags_reg[CIE_F_C];
    end
  end

  assign scan_mode = (i_op == CIE_OP_FIRST_ONE_LOW_SCAN_OP) ? 2'h2 : (i_op == CIE_OP_FIRST_ONE_HIGH_SCAN_OP) ? 2'h1 : 2'h0;
  assign dist_d    = $signed(i_opa) - $signed(i_opb);

  cie_bitscan #(.W(DW)) u_scan (
    .i_val  (i_opa),
    .i_mode (scan_mode),
    .o_pos  (scan_pos),
    .o_none (scan_none)
  );
  cie_sqacc #(.AW(CIE_AW)) u_mac (
    .i_a     ((i_op == CIE_OP_DIST || i_op == CIE_OP_DIST_ACC) ? dist_d : $signed(i_opa)),
    .i_b     ((i_op == CIE_OP_MAC) ? $signed(i_opb) :
              (i_op == CIE_OP_DIST || i_op == CIE_OP_DIST_ACC) ? dist_d : $signed(i_opa)),
    .i_acc   (i_acc_sel ? accb_reg : acca_reg),
    .i_accum (i_op != CIE_OP_DIST),
    .o_acc   (mac_out),
    .o_ovf   (mac_ovf),
    .o_sat   (mac_sat)
  );

  // Divide computed at take, held until final cycle
  logic [31:0]   dvd;
  logic [DW-1:0] dq, dr;
  logic          div_zero, div_ovf;
  always_comb begin
    dvd      = {i_opc, i_opa};
    div_zero = (i_opb == '0);
    dq       = '0;
    dr       = '0;
    div_ovf  = div_zero;
    if (!div_zero) begin
      unique case (i_op)
        CIE_OP_DIV_U: begin dq = i_opa / i_opb; dr = i_opa % i_opb; end
        CIE_OP_DIV_UD: begin
          dq = 16'(dvd / 32'(i_opb)); dr = 16'(dvd % 32'(i_opb));
          div_ovf = (dvd / 32'(i_opb)) > 32'h0000ffff;
        end
        CIE_OP_DIV_SD: begin
          dq = 16'($signed(dvd) / $signed(32'(signed'(i_opb))));
          dr = 16'($signed(dvd) % $signed(32'(signed'(i_opb))));
        end
        CIE_OP_FRACTIONAL_DIVIDE_OP: begin
          dq = 16'($signed({i_opa[DW-1], i_opa, 15'h0}) / $signed(32'(signed'(i_opb))));
          div_ovf = ($signed(i_opa) >= $signed(i_opb)) == ($signed(i_opb) > 0);
        end
        default: begin
          dq = 16'($signed(i_opa) / $signed(i_opb));
          dr = 16'($signed(i_opa) % $signed(i_opb));
        end
      endcase
    end
  end

  // ----------------------------------------
  // Results and flags
  // ----------------------------------------
  logic [DW-1:0]     pend_res, pend_rem;
  logic              pend_wr;
  logic [13:0]       irq_cnt_reg;
  logic [DW-1:0]     shr;
  logic              lit_bad;
  assign shr     = i_opa >> i_lit[4:0];
  assign lit_bad = i_byte_mode ? (i_lit > CIE_LIT_BYTE_MAX) : (i_lit > CIE_LIT_WORD_MAX);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flags_reg <= CIE_FLAGS_RST;
      acca_reg  <= '0;
      accb_reg  <= '0;
      pend_res  <= '0;
      pend_rem  <= '0;
      pend_wr   <= 1'b0;
      o_done    <= 1'b0;
      o_wr_en   <= 1'b0;
      o_result  <= '0;
      o_remainder <= '0;
      o_awb_wr  <= 1'b0;
      o_awb_reg <= CIE_AWB_REG;
      o_awb_data <= '0;
      o_w13_next <= '0;
      o_lit_err <= 1'b0;
    end else if (i_ce) begin
      o_done   <= 1'b0;
      o_wr_en  <= 1'b0;
      o_awb_wr <= 1'b0;
      if (take && !i_word2_alone) begin
        o_lit_err <= (i_op == CIE_OP_IOR_LIT) && lit_bad;
        unique case (i_op)
          CIE_OP_DAW: begin
            pend_res <= daw_v; pend_wr <= 1'b1;
            flags_reg[CIE_F_C] <= daw_c;
          end
          CIE_OP_BIT_CHANGE_SCAN_OP, CIE_OP_FIRST_ONE_HIGH_SCAN_OP, CIE_OP_FIRST_ONE_LOW_SCAN_OP: begin
            pend_res <= DW'(scan_pos); pend_wr <= 1'b1;
            flags_reg[CIE_F_C] <= scan_none;
          end
          CIE_OP_LSR1: begin
            pend_res <= i_opa >> 1; pend_wr <= 1'b1;
            flags_reg[CIE_F_C]  <= i_opa[0];
            flags_reg[CIE_F_N]  <= 1'b0;
            flags_reg[CIE_F_OV] <= 1'b0;
            flags_reg[CIE_F_Z]  <= (i_opa[DW-1:1] == '0);
          end
          CIE_OP_LSRN: begin
            pend_res <= shr; pend_wr <= 1'b1;
            flags_reg[CIE_F_N] <= shr[DW-1];
            flags_reg[CIE_F_Z] <= (shr == '0);
          end
          CIE_OP_DIST, CIE_OP_DIST_ACC, CIE_OP_MAC, CIE_OP_SQR_ACC: begin
            if (i_acc_sel) accb_reg <= mac_out;
            else           acca_reg <= mac_out;
            flags_reg[i_acc_sel ? CIE_F_OB : CIE_F_OA] <= mac_ovf;
            flags_reg[i_acc_sel ? CIE_F_SB : CIE_F_SA] <= mac_sat;
            flags_reg[CIE_F_OAB] <= mac_ovf | flags_reg[i_acc_sel ? CIE_F_OA : CIE_F_OB];
            flags_reg[CIE_F_SAB] <= mac_sat | flags_reg[CIE_F_SAB];
            pend_wr <= 1'b0;
            if (i_op == CIE_OP_MAC && i_awb_en) begin
              o_awb_wr   <= 1'b1;
              o_awb_reg  <= CIE_AWB_REG;
              o_awb_data <= i_acc_sel ? acca_reg[31:16] : accb_reg[31:16];
              o_w13_next <= i_awb_ind ? i_w13 + CIE_AWB_STEP : i_w13;
            end
          end
          CIE_OP_DIV_S, CIE_OP_DIV_SD, CIE_OP_DIV_U, CIE_OP_DIV_UD, CIE_OP_FRACTIONAL_DIVIDE_OP: begin
            pend_res <= dq; pend_rem <= dr; pend_wr <= 1'b1;
            flags_reg[CIE_F_N]  <= dq[DW-1];
            flags_reg[CIE_F_Z]  <= (dr == '0);
            flags_reg[CIE_F_C]  <= div_zero;
            flags_reg[CIE_F_OV] <= div_ovf;
          end
          default: pend_wr <= 1'b0;
        endcase
        if (cyc_need == CIE_ONE_CYC) o_done <= 1'b1;
      end else if (take) begin
        o_done <= 1'b1;
        pend_wr <= 1'b0;
      end
      if ((take && cyc_need == CIE_ONE_CYC) || (st_reg == CIE_BUSY && cnt_reg == 5'h01)) begin
        if (st_reg == CIE_BUSY) o_done <= 1'b1;
        o_wr_en     <= take ? (i_op inside {CIE_OP_DAW, CIE_OP_BIT_CHANGE_SCAN_OP, CIE_OP_FIRST_ONE_HIGH_SCAN_OP,
                       CIE_OP_FIRST_ONE_LOW_SCAN_OP, CIE_OP_LSR1, CIE_OP_LSRN}) & !i_word2_alone : pend_wr;
        o_result    <= take ? (i_op == CIE_OP_DAW ? daw_v : i_op == CIE_OP_LSR1 ? i_opa >> 1 :
                       i_op == CIE_OP_LSRN ? shr : DW'(scan_pos)) : pend_res;
        o_remainder <= pend_rem;
      end
    end
  end

  // ----------------------------------------
  // Interrupt hold and hardware loop
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irq_cnt_reg <= '0;
    end else if (i_ce) begin
      if (take && i_op == CIE_OP_IRQ_HOLD && !i_word2_alone)
        irq_cnt_reg <= 14'(i_lit);
      else if (irq_cnt_reg != '0)
        irq_cnt_reg <= irq_cnt_reg - 14'h0001;
    end
  end
  assign o_irq_block = (irq_cnt_reg != '0);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_loop_act   <= 1'b0;
      o_loop_count <= '0;
    end else if (i_ce) begin
      if (take && i_op == CIE_OP_LOOP && !i_word2_alone) begin
        o_loop_act   <= 1'b1;
        o_loop_count <= i_word2[14:0];
      end
    end
  end
  assign o_flags = flags_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_div_len: assert property (@(posedge i_mclk) disable iff (i_rst || !i_ce)
    (take && i_op == CIE_OP_DIV_U && !i_word2_alone) |=>
    (!o_ready[*8] ##1 !o_ready[*8] ##1 !o_ready ##1 (o_ready && o_done)))
    else $error("divide not held 18 cycles");
  a_jump_len: assert property (@(posedge i_mclk) disable iff (i_rst)
    (take && i_op == CIE_OP_JUMP && !i_word2_alone && i_ce) |=> (!o_ready[*3]))
    else $error("jump not four cycles");
  a_word2_nop: assert property (@(posedge i_mclk) disable iff (i_rst)
    (take && i_word2_alone) |=> (o_ready && !o_wr_en && $stable(o_flags)))
    else $error("lone second word not a nop");
  a_hold_flags: assert property (@(posedge i_mclk) disable iff (i_rst)
    (take && i_op inside {CIE_OP_IRQ_HOLD, CIE_OP_JUMP, CIE_OP_LOOP}) |=> $stable(o_flags))
    else $error("flags changed on flagless op");
  a_daw_c_only: assert property (@(posedge i_mclk) disable iff (i_rst)
    (take && i_op == CIE_OP_DAW && !i_word2_alone) |=> ($stable(o_flags[CIE_NF-1:1])))
    else $error("decimal adjust touched other flags");
  a_lsrn_nz: assert property (@(posedge i_mclk) disable iff (i_rst)
    (take && i_op == CIE_OP_LSRN && !i_word2_alone) |=> ($stable(o_flags[CIE_F_C])
      && $stable(o_flags[CIE_F_OV])))
    else $error("multi shift touched C or OV");
  a_loop_two: assert property (@(posedge i_mclk) disable iff (i_rst)
    (take && i_op == CIE_OP_LOOP && !i_word2_alone && i_ce) |=> (!o_ready ##1 o_ready))
    else $error("loop op not two cycles");
  a_awb_w13: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_awb_wr |-> (o_awb_reg == CIE_AWB_REG
      && o_w13_next == $past(i_w13) + ($past(i_awb_ind) ? CIE_AWB_STEP : 16'h0000)))
    else $error("write-back not to W13");
endmodule : cie_exec
`default_nettype wire

// File: design/cie_pkg.sv
// Purpose : Shared constants for the instruction subset execution block
// Assumes : One instruction cycle per enabled i_mclk edge
// Notes   : Op codes are this block's own decoded operation selectors
`default_nettype none
package cie_pkg;
  // ----------------------------------------
  // Operation selectors
  // ----------------------------------------
  typedef enum logic [4:0] {
    CIE_OP_NOP      = 5'h00,
    CIE_OP_DAW      = 5'h01,
    CIE_OP_IRQ_HOLD = 5'h02,
    CIE_OP_DIV_S    = 5'h03,
    CIE_OP_DIV_SD   = 5'h04,
    CIE_OP_DIV_U    = 5'h05,
    CIE_OP_DIV_UD   = 5'h06,
    CIE_OP_FRACTIONAL_DIVIDE_OP     = 5'h07,
    CIE_OP_LOOP     = 5'h08,
    CIE_OP_DIST     = 5'h09,
    CIE_OP_DIST_ACC = 5'h0a,
    CIE_OP_BIT_CHANGE_SCAN_OP     = 5'h0b,
    CIE_OP_FIRST_ONE_HIGH_SCAN_OP     = 5'h0c,
    CIE_OP_FIRST_ONE_LOW_SCAN_OP     = 5'h0d,
    CIE_OP_JUMP     = 5'h0e,
    CIE_OP_LSR1     = 5'h0f,
    CIE_OP_LSRN     = 5'h10,
    CIE_OP_MAC      = 5'h11,
    CIE_OP_SQR_ACC  = 5'h12,
    CIE_OP_MOVD     = 5'h13,
    CIE_OP_SKIP     = 5'h14,
    CIE_OP_LOGIC    = 5'h15,
    CIE_OP_IOR_LIT  = 5'h16
  } cie_op_t;

  // ----------------------------------------
  // Widths and cycle counts
  // ----------------------------------------
  localparam int          CIE_DW          = 16;
  localparam int          CIE_AW          = 40;
  localparam int          CIE_WORD2_ZERO  = 8;
  localparam logic [4:0]  CIE_DIV_CYC     = 5'h12;   // 18
  localparam logic [4:0]  CIE_JUMP_CYC    = 5'h04;
  localparam logic [4:0]  CIE_TWO_CYC     = 5'h02;
  localparam logic [4:0]  CIE_ONE_CYC     = 5'h01;
  localparam logic [4:0]  CIE_SKIP2_CYC   = 5'h03;
  localparam logic [9:0]  CIE_LIT_BYTE_MAX = 10'h0ff;
  localparam logic [9:0]  CIE_LIT_WORD_MAX = 10'h3ff;
  localparam logic [3:0]  CIE_AWB_REG     = 4'hd;    // W13
  localparam logic [15:0] CIE_AWB_STEP    = 16'h0002;
  // Status vector bit positions
  localparam int CIE_F_C   = 0;
  localparam int CIE_F_Z   = 1;
  localparam int CIE_F_OV  = 2;
  localparam int CIE_F_N   = 3;
  localparam int CIE_F_OA  = 4;
  localparam int CIE_F_OB  = 5;
  localparam int CIE_F_SA  = 6;
  localparam int CIE_F_SB  = 7;
  localparam int CIE_F_OAB = 8;
  localparam int CIE_F_SAB = 9;
  localparam int CIE_NF    = 10;
  localparam logic [9:0] CIE_FLAGS_RST = 10'h000;
endpackage : cie_pkg
`default_nettype wire

// File: design/cie_bitscan.sv
// Purpose : Bit position finder for the scan operations
// Assumes : Position numbering as the scan direction counts
// Notes   : Found flag drives carry when no match
`default_nettype none
module cie_bitscan #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] i_val,   // Value to scan
  input  wire logic [1:0]   i_mode,  // 0 change-from-top, 1 one-from-top, 2 one-from-bottom
  output logic      [4:0]   o_pos,   // Position found
  output logic              o_none   // No match found
);
  // ----------------------------------------
  // Scan
  // ----------------------------------------
  always_comb begin
    o_pos  = 5'h00;
    o_none = 1'b1;
    if (i_mode == 2'h2) begin
      for (int i = W - 1; i >= 0; i--) begin
        if (i_val[i]) begin
          o_pos  = 5'(i + 1);
          o_none = 1'b0;
        end
      end
    end else if (i_mode == 2'h1) begin
      for (int i = 0; i < W; i++) begin
        if (i_val[i]) begin
          o_pos  = 5'(W - i);
          o_none = 1'b0;
        end
      end
    end else begin
      // Signed normalise count: distance to first change below the sign bit
      for (int i = 0; i < W - 1; i++) begin
        if (i_val[i] != i_val[W-1]) begin
          o_pos  = 5'(W - 1 - i);
          o_none = 1'b0;
        end
      end
      o_pos = 5'(0) - o_pos + 5'(1);
    end
  end
endmodule : cie_bitscan
`default_nettype wire

// File: design/cie_sqacc.sv
// Purpose : Square/multiply into a 40-bit accumulator with flags
// Assumes : Signed fractional operands
// Notes   : Saturation is not applied, only flagged
`default_nettype none
module cie_sqacc #(
  parameter int AW = 40
) (
  input  wire logic signed [15:0]   i_a,     // Multiplicand
  input  wire logic signed [15:0]   i_b,     // Multiplier
  input  wire logic        [AW-1:0] i_acc,   // Current accumulator
  input  wire logic                 i_accum, // Add to accumulator
  output logic             [AW-1:0] o_acc,   // New accumulator
  output logic                      o_ovf,   // Beyond 32-bit range
  output logic                      o_sat    // Beyond 40-bit range
);
  logic signed [31:0] prod;
  logic signed [AW:0] sum;
  always_comb begin
    prod  = i_a * i_b;
    sum   = i_accum ? $signed({i_acc[AW-1], i_acc}) + (AW+1)'(prod)
                    : (AW+1)'(prod);
    o_acc = sum[AW-1:0];
    o_sat = sum[AW] != sum[AW-1];
    o_ovf = ~(&sum[AW-1:31] | ~|sum[AW-1:31]);
  end
endmodule : cie_sqacc
`default_nettype wire

// File: test/test_cie_exec.sv
// Purpose : Self-checking bench for the instruction subset execution block
// Assumes : Ops go one at a time, each after the previous one completes
// Notes   : Latency counts edges from the take edge to the o_done cycle
`default_nettype none
module test_cie_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import cie_pkg::*;
  typedef struct {
    int lat; int t; logic [9:0] hold; logic [9:0] pre; logic [9:0] fm; logic [9:0] fv;
    logic [1:0] cr; logic [15:0] res; logic [15:0] rem; logic cle; logic le;
  } cie_exp_t;
  logic        i_mclk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_valid = 1'b0;
  logic        i_word2_alone = 1'b0, i_cond_true = 1'b0, i_skip_two = 1'b0;
  logic        i_sfr_access = 1'b0, i_table_read = 1'b0, i_jump_long = 1'b0;
  logic        i_byte_mode = 1'b0, i_acc_sel = 1'b0, i_awb_en = 1'b0, i_awb_ind = 1'b0;
  cie_op_t     i_op = CIE_OP_NOP;
  logic [23:0] i_word2 = 24'h000000;
  logic [15:0] i_opa = 16'h0000, i_opb = 16'h0000, i_opc = 16'h0000, i_w13 = 16'h1000;
  logic [9:0]  i_lit = 10'h000;
  logic        o_ready, o_done, o_wr_en, o_awb_wr, o_irq_block, o_loop_act, o_lit_err;
  logic [15:0] o_result, o_remainder, o_awb_data, o_w13_next;
  logic [3:0]  o_awb_reg;
  logic [14:0] o_loop_count;
  logic [9:0]  o_flags, flags_q;
  int          fail_count = 0, cmp_count = 0, n = 0;
  cie_exp_t    ex, e;
  cie_exp_t    q[$];

  always #10 i_mclk = ~i_mclk;

  cie_exec u_cie_exec (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_valid(i_valid), .i_op(i_op),
    .i_word2_alone(i_word2_alone), .i_word2(i_word2), .i_cond_true(i_cond_true),
    .i_skip_two(i_skip_two), .i_sfr_access(i_sfr_access), .i_table_read(i_table_read),
    .i_jump_long(i_jump_long), .i_byte_mode(i_byte_mode), .i_acc_sel(i_acc_sel),
    .i_awb_en(i_awb_en), .i_awb_ind(i_awb_ind), .i_opa(i_opa), .i_opb(i_opb),
    .i_opc(i_opc), .i_lit(i_lit), .i_w13(i_w13), .o_ready(o_ready), .o_done(o_done),
    .o_wr_en(o_wr_en), .o_result(o_result), .o_remainder(o_remainder),
    .o_awb_wr(o_awb_wr), .o_awb_reg(o_awb_reg), .o_awb_data(o_awb_data),
    .o_w13_next(o_w13_next), .o_flags(o_flags), .o_irq_block(o_irq_block),
    .o_loop_act(o_loop_act), .o_loop_count(o_loop_count), .o_lit_err(o_lit_err)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic ops(logic [15:0] a, logic [15:0] b, logic [15:0] c, logic [9:0] l);
    i_opa <= a;
    i_opb <= b;
    i_opc <= c;
    i_lit <= l;
  endtask : ops

  // Pre-take flags come from the last negedge, so the take edge never races
  task automatic go(cie_op_t op, int lat, logic [9:0] hold);
    int k;
    @(posedge i_mclk);
    for (k = 0; k < 50 && o_ready !== 1'b1; k++) @(posedge i_mclk);
    i_valid <= 1'b1;
    i_op    <= op;
    @(posedge i_mclk);
    ex.lat  = lat;
    ex.t    = n;
    ex.hold = hold;
    ex.pre  = flags_q;
    q.push_back(ex);
    i_valid <= 1'b0;
    for (k = 0; k < 40 && q.size() != 0; k++) @(posedge i_mclk);
    ex = '{default: 0};
  endtask : go

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(negedge i_mclk) begin
    n = n + 1;
    flags_q = o_flags;
    if (o_done === 1'b1) begin
      if (q.size() == 0) begin
        check("unexpected done", 16'h0001, 16'h0000);
      end else begin
        e = q.pop_front();
        check("latency", 16'(n - e.t), 16'(e.lat));
        check("held flags", 16'(o_flags & e.hold), 16'(e.pre & e.hold));
        check("set flags", 16'(o_flags & e.fm), 16'(e.fv));
        if (e.cr[0]) check("result", o_result, e.res);
        if (e.cr[0]) check("write enable", 16'(o_wr_en), 16'h0001);
        if (e.cr[1]) check("remainder", o_remainder, e.rem);
        if (e.cle) check("literal error", 16'(o_lit_err), 16'(e.le));
      end
    end
    if (o_awb_wr === 1'b1) begin
      check("awb reg", 16'(o_awb_reg), 16'(CIE_AWB_REG));
      check("w13 step", o_w13_next, i_w13 + 16'h0002);
    end
  end

  // Generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_mclk);
    fail_count++;
    final_report();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int k;
    logic [15:0] a, b;
    ex = '{default: 0};
    void'($urandom(32'h5fb4));
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    ops(16'h0064, 16'h0007, 16'h0000, 10'h000);
    ex.cr = 2'b11; ex.res = 16'h000e; ex.rem = 16'h0002;
    go(CIE_OP_DIV_U, 18, 10'h3f0);
    for (k = 0; k < 3; k++) begin
      a = 16'($urandom);
      b = 16'($urandom_range(127, 1));
      ops(a, b, b - 16'h0001, 10'h000);
      ex.cr = 2'b11; ex.res = 16'($signed(a) / $signed(b)); ex.rem = 16'($signed(a) % $signed(b));
      go(CIE_OP_DIV_S, 18, 10'h3f0);
      ex.cr = 2'b11; ex.res = 16'({b - 16'h0001, a} / {16'h0000, b});
      ex.rem = 16'({b - 16'h0001, a} % {16'h0000, b});
      go(CIE_OP_DIV_UD, 18, 10'h3f0);
      go(CIE_OP_DIV_SD, 18, 10'h3f0);
    end
    ops(16'h2000, 16'h4000, 16'h0000, 10'h000);
    ex.cr = 2'b01; ex.res = 16'h4000;
    go(CIE_OP_FRACTIONAL_DIVIDE_OP, 18, 10'h3f0);
    i_word2_alone <= 1'b1;
    go(CIE_OP_NOP, 1, 10'h3ff);
    i_word2_alone <= 1'b0;
    ops(16'h001a, 16'h0000, 16'h0000, 10'h000);
    ex.cr = 2'b01; ex.res = 16'h0020;
    go(CIE_OP_DAW, 1, 10'h3fe);
    ops(16'h0000, 16'h0000, 16'h0000, 10'h005);
    go(CIE_OP_IRQ_HOLD, 1, 10'h3ff);
    @(negedge i_mclk);
    check("irq hold on", 16'(o_irq_block), 16'h0001);
    repeat (12) @(negedge i_mclk);
    check("irq hold off", 16'(o_irq_block), 16'h0000);
    i_word2 <= 24'h000003;
    go(CIE_OP_LOOP, 2, 10'h3ff);
    @(negedge i_mclk);
    check("loop active", 16'(o_loop_act), 16'h0001);
    check("loop count", 16'(o_loop_count), 16'h0003);
    go(CIE_OP_MOVD, 2, 10'h3ff);
    go(CIE_OP_DIST, 1, 10'h00f);
    go(CIE_OP_DIST_ACC, 1, 10'h00f);
    ops(16'h0010, 16'h0000, 16'h0000, 10'h000);
    ex.fm = 10'h001; ex.fv = 10'h000;
    ex.cr = 2'b01; ex.res = 16'h0005;
    go(CIE_OP_FIRST_ONE_LOW_SCAN_OP, 1, 10'h3fe);
    ops(16'h0000, 16'h0000, 16'h0000, 10'h000);
    ex.fm = 10'h001; ex.fv = 10'h001;
    go(CIE_OP_FIRST_ONE_HIGH_SCAN_OP, 1, 10'h3fe);
    ex.fm = 10'h001; ex.fv = 10'h001;
    go(CIE_OP_BIT_CHANGE_SCAN_OP, 1, 10'h3fe);
    for (k = 0; k < 2; k++) begin
      i_jump_long <= k[0];
      go(CIE_OP_JUMP, 4, 10'h3ff);
    end
    ops(16'h8001, 16'h0000, 16'h0000, 10'h000);
    ex.cr = 2'b01; ex.res = 16'h4000; ex.fm = 10'h00b; ex.fv = 10'h001;
    go(CIE_OP_LSR1, 1, 10'h3f0);
    ops(16'hf000, 16'h0004, 16'h0000, 10'h004);
    ex.cr = 2'b01; ex.res = 16'h0f00; ex.fm = 10'h00a; ex.fv = 10'h000;
    go(CIE_OP_LSRN, 1, 10'h3f5);
    i_awb_en  <= 1'b1;
    i_awb_ind <= 1'b1;
    for (k = 0; k < 2; k++) begin
      i_acc_sel <= k[0];
      go(cie_op_t'(k[0] ? CIE_OP_MAC : CIE_OP_SQR_ACC), 1, 10'h00f);
    end
    for (k = 0; k < 3; k++) begin
      i_cond_true <= (k > 0);
      i_skip_two  <= (k > 1);
      go(CIE_OP_SKIP, k + 1, 10'h3ff);
    end
    i_cond_true <= 1'b0;
    for (k = 0; k < 3; k++) begin
      i_sfr_access <= (k == 1);
      i_table_read <= (k == 2);
      go(CIE_OP_LOGIC, (k > 0) ? 2 : 1, 10'h3f5);
    end
    i_table_read <= 1'b0;
    for (k = 0; k < 3; k++) begin
      i_byte_mode <= (k != 1);
      ops(16'h0000, 16'h0000, 16'h0000, (k == 0) ? 10'h100 : ((k == 1) ? 10'h3ff : 10'h0ff));
      ex.cle = 1'b1; ex.le = (k == 0);
      go(CIE_OP_IOR_LIT, 1, 10'h3f5);
    end
    // Enable low for three edges mid-jump stretches it by exactly three
    fork
      go(CIE_OP_JUMP, 7, 10'h3ff);
      begin
        repeat (3) @(posedge i_mclk);
        i_ce <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_ce <= 1'b1;
      end
    join
    final_report();
  end
endmodule : test_cie_exec
`default_nettype wire
